// ===== logic/bridge_pkg.sv
// Overview of operation
// - Provider port: untagged/customer frames get service default.
// - Customer edge: untagged/service frames get customer default.
// - Customer network port: add service default tag.
// - Registered customer VLANs map to service VLANs.
// - Native-tagged frames on provider and customer edge ports follow allow/block table.
// - VLAN ID 0 counts untagged, priority kept.
// - Writing undefined default VLAN is rejected.
// - Reset default VLAN 1, priority 0.
// - Reset ports are customer network type.
// - Core service component permanent; service tag always.
// - Reset has no customer components.
// - Transparent mode floods frames with no map hit, unless local-only management is on.
// - Local-only management stays on selected port.
// - External/internal loopback, optional MAC swap.
// - Loopback clears after timeout seconds, default 60.
// - Manual speed and duplex when negotiation off.
// - Negotiated speed reported apart from configured.
// - Track time since operational status change.
// - Up to eight radio ports, created on connect.
// - Guest terminals: no service VLANs, transparent only.
package bridge_pkg;
  localparam int CLK_HZ = 200000000;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam logic [11:0] VID_DEFAULT = 12'h001;
  localparam logic [11:0] VID_PRIORITY = 12'h000;
  localparam logic [11:0] VID_UNDEF = 12'hFFF;
  localparam logic [2:0] PCP_DEFAULT = 3'h0;
  localparam logic [15:0] LOOP_TIMEOUT_DEFAULT = 16'h003C;
  localparam int NUM_PORTS = 12;
  localparam int NUM_RADIO = 8;
  localparam int MAP_DEPTH = 16;

  localparam logic [11:0] A_PORT_SEL = 12'h000;
  localparam logic [11:0] A_PORT_CFG = 12'h004;
  localparam logic [11:0] A_PORT_VID = 12'h008;
  localparam logic [11:0] A_LOOP_TMO = 12'h00C;
  localparam logic [11:0] A_PORT_STAT = 12'h010;
  localparam logic [11:0] A_LAST_CHG = 12'h014;
  localparam logic [11:0] A_BRIDGE = 12'h018;
  localparam logic [11:0] A_MAP = 12'h01C;
  localparam logic [11:0] A_VLAN_TBL = 12'h020;
  localparam logic [11:0] A_RADIO = 12'h024;

  typedef enum logic [1:0] {
    customer_network_port = 2'h0,
    customer_edge_port = 2'h1,
    provider_network_port = 2'h2
  } net_type_t;

  typedef enum logic [1:0] {
    loop_off = 2'h0,
    loop_external = 2'h1,
    loop_internal = 2'h2
  } loop_mode_t;

  typedef enum logic [3:0] {
    spd_10hd = 4'h0, spd_10fd = 4'h1, spd_100hd = 4'h2, spd_100fd = 4'h3,
    spd_1000hd = 4'h4, spd_1000fd = 4'h5, spd_1000xhd = 4'h6, spd_1000xfd = 4'h7
  } speed_t;

  typedef struct packed {
    logic [3:0] port;
    logic s_tagged;
    logic [11:0] s_vid;
    logic c_tagged;
    logic [11:0] c_vid;
    logic [2:0] pcp;
  } frame_hdr_t;

  typedef struct packed {
    logic [3:0] port;
    logic [11:0] s_vid;
    logic c_valid;
    logic [11:0] c_vid;
    logic [2:0] pcp;
    logic forward;
    logic mgmt_only;
    logic flood_all;
    logic [1:0] loop;
    logic mac_swap;
  } frame_out_t;
endpackage

// ===== logic/loop_timer.sv
`timescale 1ns/1ps
module loop_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sec_tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [15:0] timeout,
  output logic active,
  output logic expire
);
  import bridge_pkg::*;
  logic [15:0] cnt_reg, cnt_next;
  logic act_reg, act_next, exp_reg, exp_next;

  always_comb begin
    cnt_next = cnt_reg;
    act_next = act_reg;
    exp_next = 1'b0;
    if (start) begin
      act_next = 1'b1;
      cnt_next = timeout;
    end else if (stop) begin
      act_next = 1'b0;
    end else if (act_reg && sec_tick) begin
      if (cnt_reg <= 16'h0001) begin
        act_next = 1'b0;
        exp_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
      act_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      act_reg <= act_next;
      exp_reg <= exp_next;
    end
  end

  assign active = act_reg;
  assign expire = exp_reg;
endmodule

// ===== logic/vlan_bridge_port_ingress.sv
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module vlan_bridge_port_ingress #(
  parameter int SEC_COUNT = bridge_pkg::SEC_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  input wire bridge_pkg::frame_hdr_t in_hdr,
  output logic out_valid,
  output bridge_pkg::frame_out_t out_hdr,
  input wire logic [bridge_pkg::NUM_PORTS-1:0] link_up_pin,
  input wire logic [bridge_pkg::NUM_PORTS-1:0] neg_done_pin,
  input wire logic [3:0] neg_speed,
  input wire logic [bridge_pkg::NUM_RADIO-1:0] radio_connect_pin,
  input wire logic [bridge_pkg::NUM_RADIO-1:0] radio_guest,
  output logic [bridge_pkg::NUM_RADIO-1:0] radio_port_to_terminal,
  output logic [bridge_pkg::NUM_PORTS-1:0] loop_active
);
  import bridge_pkg::*;

  // ------------------------------------------------------------
  // Per-port configuration
  // ------------------------------------------------------------
  localparam int NP = NUM_PORTS;
  net_type_t ntype_reg [NP], ntype_next [NP];
  logic [11:0] vid_reg [NP], vid_next [NP];
  logic [2:0] pcp_reg [NP], pcp_next [NP];
  loop_mode_t lmode_reg [NP], lmode_next [NP];
  logic swap_reg [NP], swap_next [NP];
  logic aneg_reg [NP], aneg_next [NP];
  speed_t spd_reg [NP], spd_next [NP];
  logic [3:0] act_spd_reg [NP], act_spd_next [NP];
  logic [15:0] tmo_reg [NP], tmo_next [NP];
  logic [31:0] last_reg [NP], last_next [NP];
  logic [3:0] sel_reg, sel_next;
  logic local_mgmt_reg, local_mgmt_next;
  logic [3:0] mgmt_port_reg, mgmt_port_next;
  logic [11:0] map_c_reg [MAP_DEPTH], map_c_next [MAP_DEPTH];
  logic [11:0] map_s_reg [MAP_DEPTH], map_s_next [MAP_DEPTH];
  logic map_v_reg [MAP_DEPTH], map_v_next [MAP_DEPTH];
  logic [4095:0] allow_reg, allow_next;
  logic [NUM_RADIO-1:0] rprov_reg, rprov_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic out_valid_reg, out_valid_next;
  frame_out_t out_reg, out_next;
  logic [NUM_RADIO-1:0] radio_reg, radio_next;
  logic [31:0] div_reg, div_next;
  logic sec_tick;
  logic [NP-1:0] lp_start, lp_stop, lp_act, lp_exp;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [NP-1:0] up_s1, up_s2, up_s3, up_reg, up_next, nd_s1, nd_s2, nd_s3;
  logic [NUM_RADIO-1:0] rc_s1, rc_s2, rc_s3, rc_reg, rc_next;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      up_s1 <= '0; up_s2 <= '0; up_s3 <= '0;
      nd_s1 <= '0; nd_s2 <= '0; nd_s3 <= '0;
      rc_s1 <= '0; rc_s2 <= '0; rc_s3 <= '0;
    end else begin
      up_s1 <= link_up_pin; up_s2 <= up_s1; up_s3 <= up_s2;
      nd_s1 <= neg_done_pin; nd_s2 <= nd_s1; nd_s3 <= nd_s2;
      rc_s1 <= radio_connect_pin; rc_s2 <= rc_s1; rc_s3 <= rc_s2;
    end
  end

  // Second-second division of the clock for timeouts and status age.
  always_comb begin
    div_next = (div_reg == 32'(SEC_COUNT - 1)) ? 32'h00000000 : div_reg + 32'h00000001;
  end
  assign sec_tick = (div_reg == 32'(SEC_COUNT - 1));

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  logic acc;
  logic [11:0] wvid;
  assign acc = psel && penable && !pready_reg;
  assign wvid = pwdata[11:0];

  always_comb begin
    sel_next = sel_reg;
    local_mgmt_next = local_mgmt_reg;
    mgmt_port_next = mgmt_port_reg;
    allow_next = allow_reg;
    rprov_next = rprov_reg;
    pready_next = acc;
    pslverr_next = 1'b0;
    prdata_next = 32'h00000000;
    lp_start = '0;
    lp_stop = '0;
    for (int i = 0; i < MAP_DEPTH; i++) begin
      map_c_next[i] = map_c_reg[i];
      map_s_next[i] = map_s_reg[i];
      map_v_next[i] = map_v_reg[i];
    end
    for (int i = 0; i < NP; i++) begin
      ntype_next[i] = ntype_reg[i];
      vid_next[i] = vid_reg[i];
      pcp_next[i] = pcp_reg[i];
      lmode_next[i] = lp_exp[i] ? loop_off : lmode_reg[i];
      swap_next[i] = swap_reg[i];
      aneg_next[i] = aneg_reg[i];
      spd_next[i] = spd_reg[i];
      tmo_next[i] = tmo_reg[i];
      act_spd_next[i] = act_spd_reg[i];
      if (aneg_reg[i] && nd_s3[i] && nd_s2[i]) begin
        act_spd_next[i] = neg_speed;
      end else if (!aneg_reg[i]) begin
        act_spd_next[i] = spd_reg[i];
      end
      last_next[i] = (up_reg[i] != up_next[i]) ? 32'h00000000 :
                     (sec_tick ? last_reg[i] + 32'h00000001 : last_reg[i]);
    end
    if (acc && pwrite) begin
      unique case (paddr)
        A_PORT_SEL: sel_next = (pwdata[3:0] < 4'(NP)) ? pwdata[3:0] : sel_reg;
        A_PORT_CFG: begin
          // Guest radio ports stay transparent; other types are refused.
          if ((32'(sel_reg) >= 32'(NP - NUM_RADIO)) &&
              radio_guest[3'(sel_reg - 4'(NP - NUM_RADIO))] &&
              pwdata[1:0] != customer_network_port) begin
            pslverr_next = 1'b1;
          end else if (pwdata[1:0] == 2'h3) begin
            pslverr_next = 1'b1;
          end else begin
            ntype_next[sel_reg] = net_type_t'(pwdata[1:0]);
          end
          if (pwdata[3:2] == 2'h3) begin
            pslverr_next = 1'b1;
          end else begin
            lmode_next[sel_reg] = loop_mode_t'(pwdata[3:2]);
            lp_start[sel_reg] = (pwdata[3:2] != loop_off);
            lp_stop[sel_reg] = (pwdata[3:2] == loop_off);
          end
          swap_next[sel_reg] = pwdata[4];
          aneg_next[sel_reg] = pwdata[5];
          spd_next[sel_reg] = speed_t'({1'b0, pwdata[10:8]});
        end
        A_PORT_VID: begin
          if (wvid == VID_UNDEF || wvid == VID_PRIORITY) begin
            pslverr_next = 1'b1;
          end else begin
            vid_next[sel_reg] = wvid;
            pcp_next[sel_reg] = pwdata[14:12];
          end
        end
        A_LOOP_TMO: tmo_next[sel_reg] = pwdata[15:0];
        A_BRIDGE: begin
          local_mgmt_next = pwdata[0];
          mgmt_port_next = pwdata[7:4];
        end
        A_MAP: begin
          map_c_next[pwdata[31:28]] = pwdata[11:0];
          map_s_next[pwdata[31:28]] = pwdata[23:12];
          map_v_next[pwdata[31:28]] = pwdata[24];
        end
        A_VLAN_TBL: allow_next[pwdata[11:0]] = pwdata[12];
        A_RADIO: rprov_next = pwdata[NUM_RADIO-1:0];
        default: pslverr_next = !(paddr == A_PORT_STAT || paddr == A_LAST_CHG);
      endcase
    end else if (acc) begin
      unique case (paddr)
        A_PORT_SEL: prdata_next = {28'h0000000, sel_reg};
        A_PORT_CFG: prdata_next = {20'h00000, spd_reg[sel_reg], 2'h0, aneg_reg[sel_reg],
                                   swap_reg[sel_reg], lmode_reg[sel_reg], ntype_reg[sel_reg]};
        A_PORT_VID: prdata_next = {17'h0, pcp_reg[sel_reg], vid_reg[sel_reg]};
        A_LOOP_TMO: prdata_next = {16'h0000, tmo_reg[sel_reg]};
        A_PORT_STAT: prdata_next = {26'h0, lp_act[sel_reg], act_spd_reg[sel_reg],
                                    up_reg[sel_reg]};
        A_LAST_CHG: prdata_next = last_reg[sel_reg];
        A_BRIDGE: prdata_next = {24'h000000, mgmt_port_reg, 3'h0, local_mgmt_reg};
        A_RADIO: prdata_next = {24'h000000, radio_reg};
        default: pslverr_next = !(paddr == A_MAP || paddr == A_VLAN_TBL);
      endcase
    end
  end

  // ------------------------------------------------------------
  // Ingress classification
  // ------------------------------------------------------------
  logic s_native, c_native;
  logic [3:0] p;
  logic map_hit;
  logic [11:0] map_vid;
  always_comb begin
    p = in_hdr.port;
    map_hit = 1'b0;
    map_vid = VID_DEFAULT;
    for (int i = 0; i < MAP_DEPTH; i++) begin
      if (map_v_reg[i] && in_hdr.c_tagged && map_c_reg[i] == in_hdr.c_vid && !map_hit) begin
        map_hit = 1'b1;
        map_vid = map_s_reg[i];
      end
    end
    // A zero VID carries only priority and counts as untagged.
    s_native = in_hdr.s_tagged && in_hdr.s_vid != VID_PRIORITY;
    c_native = in_hdr.c_tagged && in_hdr.c_vid != VID_PRIORITY;
    out_valid_next = in_valid && (32'(p) < NP);
    out_next = '0;
    out_next.port = p;
    out_next.pcp = in_hdr.pcp;
    out_next.c_valid = in_hdr.c_tagged;
    out_next.c_vid = in_hdr.c_vid;
    out_next.forward = 1'b1;
    out_next.loop = lmode_reg[p];
    out_next.mac_swap = swap_reg[p] && lmode_reg[p] != loop_off;
    out_next.mgmt_only = local_mgmt_reg && p == mgmt_port_reg;
    // Every frame leaves with a service VLAN, the core component is fixed.
    unique case (ntype_reg[p])
      provider_network_port: begin
        if (s_native) begin
          out_next.s_vid = in_hdr.s_vid;
          out_next.forward = allow_reg[in_hdr.s_vid];
        end else begin
          out_next.s_vid = vid_reg[p];
          // A priority-tagged customer frame keeps its own priority.
          if (!in_hdr.s_tagged && !in_hdr.c_tagged) out_next.pcp = pcp_reg[p];
        end
      end
      customer_edge_port: begin
        out_next.c_valid = 1'b1;
        out_next.s_vid = VID_DEFAULT;
        if (c_native) begin
          out_next.c_vid = in_hdr.c_vid;
          out_next.forward = allow_reg[in_hdr.c_vid];
        end else begin
          out_next.c_vid = vid_reg[p];
          if (!in_hdr.c_tagged) out_next.pcp = pcp_reg[p];
        end
      end
      default: begin
        out_next.s_vid = map_hit ? map_vid : vid_reg[p];
        out_next.flood_all = !map_hit && !local_mgmt_reg;
        if (!in_hdr.c_tagged) out_next.pcp = pcp_reg[p];
      end
    endcase
    if (local_mgmt_reg && p != mgmt_port_reg) out_next.mgmt_only = 1'b0;
  end

  // ------------------------------------------------------------
  // Radio ports and status
  // ------------------------------------------------------------
  always_comb begin
    up_next = (up_s2 == up_s3) ? up_s3 : up_reg;
    rc_next = (rc_s2 == rc_s3) ? rc_s3 : rc_reg;
    radio_next = rc_reg | (rprov_reg & ~radio_guest);
  end

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : gen_loop
      loop_timer u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .sec_tick(sec_tick),
        .start(lp_start[g]),
        .stop(lp_stop[g]),
        .timeout(tmo_reg[g]),
        .active(lp_act[g]),
        .expire(lp_exp[g])
      );
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < NP; i++) begin
        ntype_reg[i] <= customer_network_port;
        vid_reg[i] <= VID_DEFAULT;
        pcp_reg[i] <= PCP_DEFAULT;
        lmode_reg[i] <= loop_off;
        swap_reg[i] <= 1'b0;
        aneg_reg[i] <= 1'b1;
        spd_reg[i] <= spd_1000fd;
        act_spd_reg[i] <= 4'h0;
        tmo_reg[i] <= LOOP_TIMEOUT_DEFAULT;
        last_reg[i] <= 32'h00000000;
      end
      for (int i = 0; i < MAP_DEPTH; i++) begin
        map_c_reg[i] <= 12'h000;
        map_s_reg[i] <= 12'h000;
        map_v_reg[i] <= 1'b0;
      end
      allow_reg <= {4096{1'b1}};
      sel_reg <= 4'h0;
      local_mgmt_reg <= 1'b0;
      mgmt_port_reg <= 4'h0;
      rprov_reg <= '0;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      out_reg <= '0;
      radio_reg <= '0;
      up_reg <= '0;
      rc_reg <= '0;
      div_reg <= 32'h00000000;
    end else begin
      for (int i = 0; i < NP; i++) begin
        ntype_reg[i] <= ntype_next[i];
        vid_reg[i] <= vid_next[i];
        pcp_reg[i] <= pcp_next[i];
        lmode_reg[i] <= lmode_next[i];
        swap_reg[i] <= swap_next[i];
        aneg_reg[i] <= aneg_next[i];
        spd_reg[i] <= spd_next[i];
        act_spd_reg[i] <= act_spd_next[i];
        tmo_reg[i] <= tmo_next[i];
        last_reg[i] <= last_next[i];
      end
      for (int i = 0; i < MAP_DEPTH; i++) begin
        map_c_reg[i] <= map_c_next[i];
        map_s_reg[i] <= map_s_next[i];
        map_v_reg[i] <= map_v_next[i];
      end
      allow_reg <= allow_next;
      sel_reg <= sel_next;
      local_mgmt_reg <= local_mgmt_next;
      mgmt_port_reg <= mgmt_port_next;
      rprov_reg <= rprov_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      out_valid_reg <= out_valid_next;
      out_reg <= out_next;
      radio_reg <= radio_next;
      up_reg <= up_next;
      rc_reg <= rc_next;
      div_reg <= div_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign out_valid = out_valid_reg;
  assign out_hdr = out_reg;
  assign radio_port_to_terminal = radio_reg;
  assign loop_active = lp_act;
endmodule

// ===== verification/bridge_asserts.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Timing and content checks on the register bus, the ingress stream and loopback start.
// ------------------------------------------------------------
module bridge_asserts
  import bridge_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic in_valid,
  input wire bridge_pkg::frame_hdr_t in_hdr,
  input wire logic out_valid,
  input wire bridge_pkg::frame_out_t out_hdr,
  input wire logic [bridge_pkg::NUM_PORTS-1:0] loop_active
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_out_follows;
    in_valid && in_hdr.port < 4'hC |=> out_valid;
  endproperty
  a_out_follows: assert property (p_out_follows) else $error("frame lost");
  property p_out_cause;
    out_valid |-> $past(in_valid && in_hdr.port < 4'hC);
  endproperty
  a_out_cause: assert property (p_out_cause) else $error("frame from nowhere");
  property p_port_kept;
    out_valid |-> out_hdr.port == $past(in_hdr.port);
  endproperty
  a_port_kept: assert property (p_port_kept) else $error("port changed");
  property p_svid_present;
    out_valid |-> out_hdr.s_vid != VID_PRIORITY && out_hdr.s_vid != VID_UNDEF;
  endproperty
  a_svid_present: assert property (p_svid_present) else $error("no service tag");
  property p_pcp_kept;
    out_valid && $past(in_hdr.c_tagged && in_hdr.c_vid == VID_PRIORITY)
      |-> out_hdr.pcp == $past(in_hdr.pcp);
  endproperty
  a_pcp_kept: assert property (p_pcp_kept) else $error("priority lost");
  property p_apb_answer;
    psel && penable && !pready |=> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("no bus answer");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_err_ready;
    pslverr |-> pready && $past(psel && penable);
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("stray error");
  property p_loop_start;
    $rose(|loop_active) |-> $past(psel && pwrite, 1) || $past(psel && pwrite, 2)
      || $past(psel && pwrite, 3);
  endproperty
  a_loop_start: assert property (p_loop_start) else $error("loop without write");
endmodule
bind vlan_bridge_port_ingress bridge_asserts u_bridge_asserts (.sys_clk, .rst, .psel,
  .penable, .pwrite, .pready, .pslverr, .in_valid, .in_hdr, .out_valid, .out_hdr,
  .loop_active);

// ===== verification/eth_station.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Stations and radio terminals on the line side.
// ------------------------------------------------------------
module eth_station
  import bridge_pkg::*;
(
  input wire logic sys_clk,
  output logic in_valid,
  output bridge_pkg::frame_hdr_t in_hdr,
  output logic [bridge_pkg::NUM_PORTS-1:0] link_up_pin,
  output logic [bridge_pkg::NUM_PORTS-1:0] neg_done_pin,
  output logic [3:0] neg_speed,
  output logic [bridge_pkg::NUM_RADIO-1:0] radio_connect_pin,
  output logic [bridge_pkg::NUM_RADIO-1:0] radio_guest
);
  logic busy;
  initial begin
    busy = 1'b0;
    in_valid = 1'b0;
    in_hdr = '0;
    link_up_pin = '0;
    neg_done_pin = '0;
    neg_speed = 4'h0;
    radio_connect_pin = '0;
    radio_guest = '0;
  end
  // Idle header wires toggle, so a stale header can never pass for a fresh one.
  always @(posedge sys_clk) begin
    if (!busy) begin
      in_hdr <= ~in_hdr;
    end
  end
  task automatic send(input frame_hdr_t h, input int gap);
    busy = 1'b1;
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    in_valid <= 1'b1;
    in_hdr <= h;
    @(posedge sys_clk);
    in_valid <= 1'b0;
    busy = 1'b0;
  endtask
  task automatic set_pins(input logic [11:0] up, input logic [3:0] spd,
                          input logic [7:0] conn, input logic [7:0] guest);
    @(posedge sys_clk);
    link_up_pin <= up;
    neg_done_pin <= up;
    neg_speed <= spd;
    radio_connect_pin <= conn;
    radio_guest <= guest;
  endtask
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Ingress policy bench.
// ------------------------------------------------------------
module tb_top;
  import bridge_pkg::*;
  localparam int SECS = 20;
  localparam logic [31:0] CFG_BASE = 32'h0000_0520;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, t0;
  logic pready, pslverr, err, in_valid, out_valid;
  frame_hdr_t in_hdr, h;
  frame_out_t out_hdr, o;
  logic [NUM_PORTS-1:0] link_up_pin, neg_done_pin, loop_active;
  logic [3:0] neg_speed;
  logic [NUM_RADIO-1:0] radio_connect_pin, radio_guest, radio_port_to_terminal;
  net_type_t typ [4];
  logic [11:0] pv [4];
  logic [11:0] v;
  int p;
  int n_errors = 0;
  int n_tests = 0;
  always #2.5 sys_clk = ~sys_clk;
  vlan_bridge_port_ingress #(.SEC_COUNT(SECS)) u_vlan_bridge_port_ingress (.sys_clk, .rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .in_valid,
    .in_hdr, .out_valid, .out_hdr, .link_up_pin, .neg_done_pin, .neg_speed,
    .radio_connect_pin, .radio_guest, .radio_port_to_terminal, .loop_active);
  eth_station u_eth_station (.sys_clk, .in_valid, .in_hdr, .link_up_pin, .neg_done_pin,
    .neg_speed, .radio_connect_pin, .radio_guest);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [31:0] q, input logic [31:0] c, input logic [11:0] d);
    apb(1'b1, A_PORT_SEL, q);
    apb(1'b1, A_PORT_CFG, c);
    apb(1'b1, A_PORT_VID, {20'h0, d});
  endtask
  task automatic frame(input frame_hdr_t f);
    u_eth_station.send(f, $urandom_range(0, 2));
    @(posedge sys_clk);
    check(out_valid, 1'b1);
    o = out_hdr;
  endtask
  function automatic frame_hdr_t mk(input logic [3:0] q, input logic st, input logic [11:0] sv,
                                    input logic ct, input logic [11:0] cv, input logic [2:0] pc);
    return {q, st, sv, ct, cv, pc};
  endfunction
  function automatic logic [11:0] rv();
    return 12'($urandom_range(2, 4094));
  endfunction
  function automatic logic [11:0] exp_svid(input net_type_t t, input logic [11:0] d,
                                           input frame_hdr_t f);
    if (t == provider_network_port && f.s_tagged && f.s_vid != 12'h000) return f.s_vid;
    if (t == customer_edge_port) return VID_DEFAULT;
    return d;
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(95281));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, A_PORT_CFG, 32'h0);
    check(rd, CFG_BASE);
    apb(1'b0, A_PORT_VID, 32'h0);
    check(rd, {17'h0, PCP_DEFAULT, VID_DEFAULT});
    apb(1'b0, A_LOOP_TMO, 32'h0);
    check(rd, {16'h0, LOOP_TIMEOUT_DEFAULT});
    apb(1'b0, A_RADIO, 32'h0);
    check(rd, 32'h0);
    v = rv();
    frame(mk(4'h0, 1'b0, 12'h000, 1'b1, v, 3'h5));
    check(o.s_vid, VID_DEFAULT);
    check(o.c_vid, v);
    apb(1'b1, A_PORT_VID, {20'h0, VID_PRIORITY});
    check(err, 1'b1);
    apb(1'b1, A_PORT_VID, {20'h0, VID_UNDEF});
    check(err, 1'b1);
    apb(1'b0, A_PORT_VID, 32'h0);
    check(rd, {20'h0, VID_DEFAULT});
    apb(1'b0, 12'h0FC, 32'h0);
    check(err, 1'b1);
    $display("test defaults done");
    for (int q = 0; q < 4; q++) begin
      typ[q] = (q < 3) ? net_type_t'(q) : net_type_t'($urandom_range(0, 2));
      pv[q] = rv();
      cfg(q, CFG_BASE | 32'(typ[q]), pv[q]);
    end
    for (int i = 0; i < 30; i++) begin
      p = $urandom_range(0, 3);
      h = mk(4'(p), 1'($urandom_range(0, 1)) & (typ[p] != customer_network_port),
             (i % 4 == 0) ? 12'h000 : rv(), 1'($urandom_range(0, 1)),
             (i % 3 == 0) ? 12'h000 : rv(), 3'($urandom_range(0, 7)));
      frame(h);
      check(o.s_vid, exp_svid(typ[p], pv[p], h));
      check(o.forward, 1'b1);
      if (typ[p] == customer_edge_port)
        check(o.c_vid, (h.c_tagged && h.c_vid != 12'h000) ? h.c_vid : pv[p]);
    end
    $display("test random done");
    v = rv();
    cfg(3, CFG_BASE, pv[3]);
    apb(1'b1, A_MAP, {4'h0, 3'h0, 1'b1, v, 12'h0AB});
    frame(mk(4'h3, 1'b0, 12'h000, 1'b1, 12'h0AB, 3'h1));
    check(o.s_vid, v);
    frame(mk(4'h3, 1'b0, 12'h000, 1'b1, 12'h0AC, 3'h1));
    check(o.s_vid, pv[3]);
    check(o.flood_all, 1'b1);
    apb(1'b1, A_BRIDGE, 32'h0000_0031);
    frame(mk(4'h3, 1'b0, 12'h000, 1'b0, 12'h000, 3'h1));
    check(o.mgmt_only, 1'b1);
    check(o.flood_all, 1'b0);
    frame(mk(4'h0, 1'b0, 12'h000, 1'b0, 12'h000, 3'h1));
    check(o.mgmt_only, 1'b0);
    cfg(1, CFG_BASE | 32'h2, pv[1]);
    apb(1'b1, A_VLAN_TBL, 32'h0000_0123);
    frame(mk(4'h1, 1'b1, 12'h123, 1'b0, 12'h000, 3'h2));
    check(o.forward, 1'b0);
    check(o.s_vid, 12'h123);
    frame(mk(4'h1, 1'b1, 12'h124, 1'b0, 12'h000, 3'h2));
    check(o.forward, 1'b1);
    $display("test map and table done");
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, A_PORT_CFG, (s << 8) | 2);
      apb(1'b0, A_PORT_STAT, 32'h0);
      check(rd[4:1], s[3:0]);
    end
    apb(1'b1, A_PORT_CFG, CFG_BASE | 32'h2);
    u_eth_station.set_pins(12'h002, 4'h3, 8'h03, 8'h02);
    repeat (8) @(posedge sys_clk);
    apb(1'b0, A_PORT_STAT, 32'h0);
    check(rd[5:0], 6'h07);
    apb(1'b0, A_PORT_CFG, 32'h0);
    check(rd[10:8], 3'h5);
    apb(1'b0, A_LAST_CHG, 32'h0);
    t0 = rd;
    repeat (3 * SECS) @(posedge sys_clk);
    apb(1'b0, A_LAST_CHG, 32'h0);
    check(rd - t0 >= 32'd2 && rd - t0 <= 32'd4, 1'b1);
    check(radio_port_to_terminal, 8'h03);
    apb(1'b1, A_PORT_SEL, 32'h5);
    apb(1'b1, A_PORT_CFG, CFG_BASE | 32'h2);
    check(err, 1'b1);
    apb(1'b1, A_RADIO, 32'h80);
    repeat (2) @(posedge sys_clk);
    check(radio_port_to_terminal, 8'h83);
    $display("test status and radio done");
    apb(1'b1, A_PORT_SEL, 32'h0);
    apb(1'b1, A_LOOP_TMO, 32'h2);
    for (int m = 1; m < 3; m++) begin
      for (int s = 0; s < 2; s++) begin
        apb(1'b1, A_PORT_CFG, CFG_BASE | (m << 2) | (s << 4));
        frame(mk(4'h0, 1'b0, 12'h000, 1'b0, 12'h000, 3'h0));
        check(o.loop, m[1:0]);
        check(o.mac_swap, s[0]);
        check(loop_active[0], 1'b1);
      end
    end
    repeat (2 * SECS + 20) @(posedge sys_clk);
    check(loop_active[0], 1'b0);
    apb(1'b0, A_PORT_CFG, 32'h0);
    check(rd[3:2], 2'h0);
    $display("test loopback done");
    tally_and_finish();
  end
endmodule
